// ---- hdl/ddr_pkg.sv ----
// Package for the distributed DMA slave register block.
// Assumes one clock domain and a byte-lane I/O access port.
package ddr_pkg;

  // Configuration-space offset of the window base address.
  localparam logic [7:0] DDR_CFG_BASE_OFS = 8'h98;
  // The window is 16 bytes, so the low four address bits select in it.
  localparam int DDR_WIN_BITS = 4;
  localparam logic [31:0] DDR_BASE_RST = 32'h0000_0000;

  // Byte offsets inside the window.
  localparam logic [3:0] DDR_COUNT_OFS = 4'h4;
  localparam logic [3:0] DDR_CMD_STAT_OFS = 4'h8;
  localparam logic [3:0] DDR_SWREQ_OFS = 4'h9;

  // Reset values and field positions.
  localparam logic [15:0] DDR_COUNT_RST = 16'h0000;
  localparam logic DDR_DISABLE_RST = 1'b0;
  localparam int DDR_CMD_DISABLE_BIT = 2;
  localparam logic [3:0] DDR_TC_RST = 4'h0;

  // Count decrement per transfer in each width.
  localparam logic [15:0] DDR_STEP_8 = 16'h0001;
  localparam logic [15:0] DDR_STEP_16 = 16'h0002;

  // Transfer mode field encodings.
  typedef enum logic [1:0] {
    DDR_MODE_DEMAND = 2'b00,
    DDR_MODE_SINGLE = 2'b01,
    DDR_MODE_BLOCK = 2'b10,
    DDR_MODE_RSVD = 2'b11
  } ddr_mode_t;

  // One I/O or configuration access, dword wide with byte enables.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ddr_access_t;

endpackage

// ---- hdl/ddr_sync.sv ----
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes the input is a slowly changing level, not a narrow pulse.
`timescale 1ns/1ps
module ddr_sync (
  input wire logic clock,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  // The first stage is read only by the second.
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
    if (srst) begin
      next_stage1 = 1'b0;
      next_sync_out = 1'b0;
    end
  end

  // Both stages are plain registers.
  always_ff @(posedge clock) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule

// ---- hdl/ddr_regs.sv ----
// Register block of a single-channel distributed DMA slave.
// Assumes decoded I/O and configuration accesses on the same clock, a
// transfer-done pulse from the data mover, and a card request pin.
// Functional notes
// - Writing offset 04h loads the 16-bit byte count; it resets to zero.
// - Reading offset 04h returns the live remaining count.
// - Eight-bit mode lowers the count by one per completed transfer.
// - Sixteen-bit mode lowers the count by two per completed transfer.
// - Command bit 2 at 08h disables the controller; zero enables, reset zero.
// - Command bits 7-3 and 1-0 are reserved and read zero.
// - Reads at 08h return status; writes there reach the command.
// - Status bits 7-4 follow the card request together.
// - Request status ignores the card request mask.
// - Status bits 3-0 all set when the channel reaches terminal count.
// - Terminal count bits clear on status read and on channel reset.
// - Any write to offset 09h enables a software transfer request.
// - Config offset 98h sets the base of the 16-byte I/O window.
// - A set mask bit makes the device ignore card requests.
// - Block mode is code 10 in mode bits 7-6.
// - Reserved locations read zero; writes to them change nothing.
`timescale 1ns/1ps
module ddr_regs
  import ddr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire ddr_access_t io_acc,
  input wire ddr_access_t cfg_acc,
  input wire logic card_dma_request,
  input wire logic card_request_mask,
  input wire ddr_mode_t transfer_mode_select,
  input wire logic word16_mode,
  input wire logic xfer_done,
  input wire logic channel_reset,
  output logic [31:0] io_rdata,
  output logic io_ack,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic controller_disable,
  output logic dma_request,
  output logic terminal_count
);

  // Window hit test, used by both read and write decoding.
  function automatic logic win_hit(input logic [31:0] a,
                                   input logic [31:0] b);
    win_hit = (a[31:DDR_WIN_BITS] == b[31:DDR_WIN_BITS]);
  endfunction

  // Byte lane enable for a byte offset in the window.
  function automatic logic lane_on(input logic [31:0] a,
                                   input logic [3:0] be,
                                   input logic [3:0] ofs);
    lane_on = (a[3:2] == ofs[3:2]) && be[ofs[1:0]];
  endfunction

  logic card_req_sync;
  logic [31:0] win_base;
  logic [15:0] transfer_count;
  logic [3:0] terminal_count_flags;
  logic sw_pending;
  logic [31:0] next_win_base;
  logic [15:0] next_transfer_count;
  logic [3:0] next_terminal_count_flags;
  logic next_sw_pending;
  logic next_controller_disable;
  logic [31:0] next_io_rdata;
  logic next_io_ack;
  logic [31:0] next_cfg_rdata;
  logic next_cfg_ack;
  logic next_dma_request;
  logic next_terminal_count;
  logic hit;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_cmd;
  logic wr_swreq;
  logic rd_stat;
  logic step_done;
  logic [15:0] step;
  logic [7:0] status_byte;

  // The card request comes from a pin, so it is synchronised first.
  ddr_sync u_req_sync (
    .clock(clock),
    .srst(srst),
    .async_in(card_dma_request),
    .sync_out(card_req_sync)
  );

  // Access decode inside the window.
  always_comb begin
    hit = win_hit(io_acc.addr, win_base);
    wr_cnt_lo = io_acc.wr && hit &&
                lane_on(io_acc.addr, io_acc.be, DDR_COUNT_OFS);
    wr_cnt_hi = io_acc.wr && hit &&
                lane_on(io_acc.addr, io_acc.be, DDR_COUNT_OFS + 4'h1);
    wr_cmd = io_acc.wr && hit &&
             lane_on(io_acc.addr, io_acc.be, DDR_CMD_STAT_OFS);
    wr_swreq = io_acc.wr && hit &&
               lane_on(io_acc.addr, io_acc.be, DDR_SWREQ_OFS);
    rd_stat = io_acc.rd && hit &&
              lane_on(io_acc.addr, io_acc.be, DDR_CMD_STAT_OFS);
    step = word16_mode ? DDR_STEP_16 : DDR_STEP_8;
    step_done = xfer_done && !controller_disable &&
                (transfer_count != DDR_COUNT_RST);
    status_byte = {{4{card_req_sync}}, terminal_count_flags};
  end

  // Next-state logic for all registers; a count write beats a decrement.
  always_comb begin
    next_win_base = win_base;
    next_transfer_count = transfer_count;
    next_terminal_count_flags = terminal_count_flags;
    next_sw_pending = sw_pending;
    next_controller_disable = controller_disable;
    next_io_rdata = 32'h0000_0000;
    next_io_ack = io_acc.wr || io_acc.rd;
    next_cfg_rdata = 32'h0000_0000;
    next_cfg_ack = cfg_acc.wr || cfg_acc.rd;
    if (cfg_acc.wr && cfg_acc.addr[7:0] == DDR_CFG_BASE_OFS) begin
      next_win_base = {cfg_acc.wdata[31:DDR_WIN_BITS],
                       {DDR_WIN_BITS{1'b0}}};
    end
    if (cfg_acc.rd && cfg_acc.addr[7:0] == DDR_CFG_BASE_OFS) begin
      next_cfg_rdata = win_base;
    end
    if (step_done) begin
      // A final odd byte in 16-bit mode still ends at zero.
      if (transfer_count <= step) begin
        next_transfer_count = DDR_COUNT_RST;
      end else begin
        next_transfer_count = transfer_count - step;
      end
    end
    if (wr_cnt_lo) begin
      next_transfer_count[7:0] = io_acc.wdata[7:0];
    end
    if (wr_cnt_hi) begin
      next_transfer_count[15:8] = io_acc.wdata[15:8];
    end
    if (wr_cmd) begin
      // Only the disable bit is stored; the others stay zero.
      next_controller_disable =
        io_acc.wdata[DDR_CMD_DISABLE_BIT];
    end
    if (rd_stat) begin
      next_io_rdata[7:0] = status_byte;
      next_terminal_count_flags = DDR_TC_RST;
    end else if (io_acc.rd && hit &&
                 io_acc.addr[3:2] == DDR_COUNT_OFS[3:2]) begin
      next_io_rdata[7:0] = io_acc.be[0] ? transfer_count[7:0] : 8'h00;
      next_io_rdata[15:8] = io_acc.be[1] ? transfer_count[15:8]
                                         : 8'h00;
    end
    // Reaching terminal count wins over the read clear.
    if (step_done && transfer_count <= step) begin
      next_terminal_count_flags = 4'hf;
      next_sw_pending = 1'b0;
    end
    if (wr_swreq) begin
      next_sw_pending = 1'b1;
    end
    if (channel_reset) begin
      next_terminal_count_flags = DDR_TC_RST;
      next_sw_pending = 1'b0;
    end
    // Software requests only drive the channel in block mode.
    next_dma_request = !next_controller_disable &&
      ((card_req_sync && !card_request_mask) ||
       (next_sw_pending &&
        transfer_mode_select == DDR_MODE_BLOCK));
    next_terminal_count = next_terminal_count_flags[0];
    if (srst) begin
      next_win_base = DDR_BASE_RST;
      next_transfer_count = DDR_COUNT_RST;
      next_terminal_count_flags = DDR_TC_RST;
      next_sw_pending = 1'b0;
      next_controller_disable = DDR_DISABLE_RST;
      next_io_rdata = 32'h0000_0000;
      next_io_ack = 1'b0;
      next_cfg_rdata = 32'h0000_0000;
      next_cfg_ack = 1'b0;
      next_dma_request = 1'b0;
      next_terminal_count = 1'b0;
    end
  end

  // Registers only; all behaviour lives in the process above.
  always_ff @(posedge clock) begin
    win_base <= next_win_base;
    transfer_count <= next_transfer_count;
    terminal_count_flags <= next_terminal_count_flags;
    sw_pending <= next_sw_pending;
    controller_disable <= next_controller_disable;
    io_rdata <= next_io_rdata;
    io_ack <= next_io_ack;
    cfg_rdata <= next_cfg_rdata;
    cfg_ack <= next_cfg_ack;
    dma_request <= next_dma_request;
    terminal_count <= next_terminal_count;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_count_write;
    wr_cnt_lo && wr_cnt_hi && !srst;
  endsequence

  a_count_load: assert property (
    s_count_write |=> transfer_count == $past(io_acc.wdata[15:0]))
    else $error("count write not loaded");
  a_count_read: assert property (
    io_acc.rd && hit && io_acc.addr[3:2] == 2'b01 && io_acc.be[1:0] == 2'b11
    |=> io_rdata[15:0] == $past(transfer_count))
    else $error("count read not live");
  a_step_8bit: assert property (
    step_done && !word16_mode && !wr_cnt_lo && !wr_cnt_hi &&
    transfer_count > 16'h0001
    |=> transfer_count == $past(transfer_count) - 16'h0001)
    else $error("8-bit step wrong");
  a_step_16bit: assert property (
    step_done && word16_mode && !wr_cnt_lo && !wr_cnt_hi &&
    transfer_count > 16'h0002
    |=> transfer_count == $past(transfer_count) - 16'h0002)
    else $error("16-bit step wrong");
  a_cmd_disable: assert property (
    wr_cmd
    |=> controller_disable == $past(io_acc.wdata[DDR_CMD_DISABLE_BIT]))
    else $error("disable bit not written");
  a_status_req: assert property (
    rd_stat |=> io_rdata[7:4] == {4{$past(card_req_sync)}})
    else $error("request status wrong");
  a_tc_set: assert property (
    step_done && transfer_count <= step && !channel_reset
    |=> terminal_count_flags == 4'hf && terminal_count)
    else $error("terminal count not set");
  a_tc_clear: assert property (
    (rd_stat || channel_reset) && !(step_done && transfer_count <= step)
    |=> terminal_count_flags == 4'h0)
    else $error("terminal count not cleared");
  a_sw_request: assert property (
    wr_swreq && !channel_reset
    |=> sw_pending)
    else $error("software request lost");
  a_mask_blocks: assert property (
    !sw_pending && !next_sw_pending && card_request_mask
    |=> !dma_request)
    else $error("masked request passed");
endmodule

// ---- bench/ddr_mover_model.sv ----
// Partner model: the card request pin and the data mover's done pulses.
// Assumes the register block's clock; drives only on the falling edge.
`timescale 1ns/1ps
module ddr_mover_model (
  input wire logic clock,
  output logic xfer_done,
  output logic card_dma_request
);
  // Both lines start quiet so the block sees no early request.
  initial begin
    xfer_done = 1'b0;
    card_dma_request = 1'b0;
  end

  // One pulse per completed transfer; a gap models a slow mover.
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(negedge clock) xfer_done = 1'b1;
      @(negedge clock) xfer_done = 1'b0;
      repeat (gap) @(negedge clock);
    end
  endtask

  // The card holds its request as a level until it withdraws it.
  task automatic request(input logic v);
    @(negedge clock) card_dma_request = v;
  endtask
endmodule

// ---- bench/ddr_regs_tb.sv ----
// Self-checking bench for the distributed DMA register block.
// Assumes the block answers each I/O access with a one-cycle ack.
`timescale 1ns/1ps
module ddr_regs_tb
  import ddr_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  ddr_access_t io_acc, cfg_acc;
  logic card_request_mask, word16_mode, channel_reset;
  ddr_mode_t transfer_mode_select;
  logic xfer_done, card_dma_request, io_ack, cfg_ack;
  logic [31:0] io_rdata, cfg_rdata, rd, base;
  logic controller_disable, dma_request, terminal_count;
  int fail_count, cmp_count;

  // A 100 ns period gives the 10 MHz bus clock.
  always #50 clock = ~clock;

  ddr_regs i_dut (.clock, .srst, .io_acc, .cfg_acc, .card_dma_request,
    .card_request_mask, .transfer_mode_select, .word16_mode, .xfer_done,
    .channel_reset, .io_rdata, .io_ack, .cfg_rdata, .cfg_ack,
    .controller_disable, .dma_request, .terminal_count);

  ddr_mover_model i_mover (.clock, .xfer_done, .card_dma_request);

  // Compares and counts; the case inequality lets no unknown slip through.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One I/O access held for one edge; the ack wait is bounded.
  task automatic io(input int w, input logic [3:0] ofs,
                    input logic [3:0] be, input logic [31:0] wd);
    int k;
    @(negedge clock);
    io_acc = '{wr: (w != 0), rd: (w == 0), addr: {base[31:4], ofs},
               be: be, wdata: wd};
    @(negedge clock);
    io_acc = '0;
    for (k = 0; k < 3 && io_ack !== 1'b1; k++) @(negedge clock);
    // A missing acknowledge is a mismatch, not a silent read of stale data.
    if (io_ack !== 1'b1) fail_count++;
    rd = io_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole sequence needs well under 1000 cycles.
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    io_acc = '0;
    cfg_acc = '0;
    card_request_mask = 1'b1;
    word16_mode = 1'b0;
    channel_reset = 1'b0;
    transfer_mode_select = DDR_MODE_DEMAND;
    base = '0;
    fail_count = 0;
    cmp_count = 0;
    cyc(12);
    srst = 1'b0;
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h0);
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'h0);
    chk({31'h0, controller_disable}, 32'h0);
    // Count load, then live readback after the 8-bit steps and after the 16-bit step.
    io(1, DDR_COUNT_OFS, 4'h3, 32'h105);
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h105);
    i_mover.burst(2, 0);
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h103);
    word16_mode = 1'b1;
    i_mover.burst(1, 3);
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h101);
    // An odd remainder runs out at zero and raises terminal count.
    io(1, DDR_COUNT_OFS, 4'h3, 32'h3);
    i_mover.burst(2, 0);
    cyc(2);
    chk({31'h0, terminal_count}, 32'h1);
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'h0f);
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'h00);
    io(1, DDR_COUNT_OFS, 4'h3, 32'h2);
    i_mover.burst(1, 1);
    channel_reset = 1'b1;
    cyc(1);
    channel_reset = 1'b0;
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'h00);
    // All-ones command: only the disable bit may take, status unchanged.
    io(1, DDR_CMD_STAT_OFS, 4'h1, 32'hff);
    chk({31'h0, controller_disable}, 32'h1);
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'h00);
    io(1, DDR_COUNT_OFS, 4'h3, 32'h4);
    i_mover.burst(1, 0);
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h4);
    io(1, DDR_CMD_STAT_OFS, 4'h1, 32'h0);
    chk({31'h0, controller_disable}, 32'h0);
    // Card request shows in status even while masked, not at the output.
    i_mover.request(1'b1);
    cyc(4);
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'hf0);
    chk({31'h0, dma_request}, 32'h0);
    card_request_mask = 1'b0;
    cyc(4);
    chk({31'h0, dma_request}, 32'h1);
    i_mover.request(1'b0);
    cyc(4);
    io(0, DDR_CMD_STAT_OFS, 4'h1, '0); chk(rd, 32'h00);
    chk({31'h0, dma_request}, 32'h0);
    // Software request in block mode with zero data still counts.
    transfer_mode_select = DDR_MODE_BLOCK;
    io(1, DDR_CMD_STAT_OFS, 4'h2, 32'h0);
    cyc(2);
    chk({31'h0, dma_request}, 32'h1);
    channel_reset = 1'b1;
    cyc(1);
    channel_reset = 1'b0;
    cyc(2);
    chk({31'h0, dma_request}, 32'h0);
    // Reserved place reads zero and swallows writes.
    io(1, 4'hc, 4'hf, 32'hffff_ffff);
    io(0, 4'hc, 4'hf, '0); chk(rd, 32'h0);
    chk({31'h0, controller_disable}, 32'h0);
    // Moving the window: the new base hits, the old one no longer does.
    @(negedge clock);
    cfg_acc = '{wr: 1'b1, rd: 1'b0, addr: 32'h98, be: 4'hf, wdata: 32'h127};
    @(negedge clock);
    // Read the base back at once; the low four bits must come back clear.
    cfg_acc = '{wr: 1'b0, rd: 1'b1, addr: 32'h98, be: 4'hf, wdata: 32'h0};
    @(negedge clock);
    cfg_acc = '0;
    chk(cfg_rdata, 32'h120);
    chk({31'h0, cfg_ack}, 32'h1);
    cyc(1);
    base = 32'h120;
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h4);
    base = 32'h0;
    io(0, DDR_COUNT_OFS, 4'h3, '0); chk(rd, 32'h0);
    report_and_stop();
  end
endmodule
